// ### design/smswp_pkg.sv
// Shared constants and types of the switch monitor serial and wake port
package smswp_pkg;

	// Word and input counts
	localparam int SMSWP_WORD_BITS = 24;
	localparam int SMSWP_PROG_INPUTS = 8;
	localparam int SMSWP_GND_INPUTS = 14;
	localparam int SMSWP_SWITCHES = SMSWP_PROG_INPUTS + SMSWP_GND_INPUTS;

	// Status word layout, most significant bit leaves first
	localparam int SMSWP_STAT_INT_POS = 23;
	localparam int SMSWP_STAT_THERM_POS = 22;
	localparam int SMSWP_STAT_PROG_LSB = 14;
	localparam int SMSWP_STAT_GND_LSB = 0;

	// Command word layout
	localparam int SMSWP_CMD_OP_MSB = 23;
	localparam int SMSWP_CMD_OP_LSB = 16;
	localparam logic [7:0] SMSWP_CMD_OP_SETTINGS = 8'h01;
	localparam int SMSWP_CMD_POL_LSB = 0;

	// Values after reset
	localparam logic [SMSWP_PROG_INPUTS-1:0] SMSWP_POL_RESET = 8'hff;
	localparam logic [SMSWP_WORD_BITS-1:0] SMSWP_WORD_RESET = 24'h000000;
	// Pin synchroniser levels {CS, SCLK, SI, INT, WAKE, supply, thermal}: idle levels
	localparam logic [6:0] SMSWP_PIN_RESET = 7'h4e;

	// Edge counter
	localparam int SMSWP_CNT_W = 5;
	localparam logic [SMSWP_CNT_W-1:0] SMSWP_CNT_FULL = 5'h18;
	localparam logic [SMSWP_CNT_W-1:0] SMSWP_CNT_MAX = 5'h1f;
	localparam logic [SMSWP_CNT_W-1:0] SMSWP_CNT_ONE = 5'h01;

	// Operating mode
	typedef enum logic {
		SMSWP_NORMAL = 1'b0,
		SMSWP_SLEEP = 1'b1
	} smswp_mode_t;

endpackage

// ### design/smswp_sync.sv
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
module smswp_sync
	import smswp_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

// ### design/smswp_decode.sv
// Comparator-to-contact decode for programmable and ground-only inputs
`timescale 1ns/10ps
module smswp_decode
	import smswp_pkg::*;
(
	input wire logic [SMSWP_PROG_INPUTS-1:0] prog_above,
	input wire logic [SMSWP_GND_INPUTS-1:0] gnd_above,
	input wire logic [SMSWP_PROG_INPUTS-1:0] polarity,
	output logic [SMSWP_PROG_INPUTS-1:0] prog_closed,
	output logic [SMSWP_GND_INPUTS-1:0] gnd_closed
);

	// Battery setting: above reference is closed; ground setting inverts
	assign prog_closed = ~(prog_above ^ polarity);

	// Ground-only inputs: below reference is closed
	assign gnd_closed = ~gnd_above;

endmodule

// ### design/smswp_top.sv
// Serial slave port, interrupt and wake logic of the switch monitor
//
// Functional notes
// - CS fall: enable SO, capture status
// - CS rise: SO back to high impedance
// - CS rise: release interrupt unless new change
// - CS rise: apply received command word
// - CS high: ignore SCLK, SI; SO off
// - SI sampled on SCLK falling edge
// - SO updates on SCLK rising edge
// - Command needs 24 bits, ones kept
// - SO tri-stated until select; closed is one
// - First rise gives bit 24, then descending
// - Both words shift MSB first, FIFO
// - Normal mode: enabled change pulls interrupt low
// - Interrupt bit shows only own interrupt
// - Sleep: CS fall wakes with logic supply
// - Sleep: interrupt line fall wakes, wake high
// - Wake output low normal, released sleep
// - Sleep: wake fall wakes, interrupt gating
// - CS and interrupt wakes need logic supply
// - Programmable polarity makes closed read one
// - Ground inputs: below reference reads closed
// - Every response carries switches and flags
`timescale 1ns/10ps
module smswp_top
	import smswp_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic SI,
	output logic SO_O,
	output logic SO_OE,
	input wire logic INT_N_I,
	output logic INT_N_O,
	output logic INT_N_OE,
	input wire logic WAKE_N_I,
	output logic WAKE_N_O,
	output logic WAKE_N_OE,
	input wire logic LOGIC_SUPPLY_OK,
	input wire logic THERMAL_FLAG,
	input wire logic [SMSWP_PROG_INPUTS-1:0] PROG_ABOVE_REF,
	input wire logic [SMSWP_GND_INPUTS-1:0] GND_ABOVE_REF,
	input wire logic [SMSWP_SWITCHES-1:0] IRQ_ENABLE,
	input wire logic SLEEP_REQ,
	output logic SLEEP_MODE,
	output logic [SMSWP_PROG_INPUTS-1:0] POLARITY,
	output logic [SMSWP_WORD_BITS-1:0] CMD_WORD,
	output logic CMD_STROBE
);

	// Synchronised pin levels
	logic cs_s;
	logic sclk_s;
	logic si_s;
	logic int_s;
	logic wake_s;
	logic vdd_s;
	logic therm_s;
	logic [SMSWP_PROG_INPUTS-1:0] prog_above_s;
	logic [SMSWP_GND_INPUTS-1:0] gnd_above_s;

	// Previous synchronised levels for edge detection
	logic cs_d;
	logic sclk_d;
	logic int_d;
	logic wake_d;

	// Serial engine state
	logic [SMSWP_WORD_BITS-1:0] shreg;
	logic [SMSWP_CNT_W-1:0] fall_cnt;
	logic so_bit;
	logic so_en;

	// Switch and interrupt state
	logic [SMSWP_PROG_INPUTS-1:0] prog_closed;
	logic [SMSWP_GND_INPUTS-1:0] gnd_closed;
	logic [SMSWP_SWITCHES-1:0] closed;
	logic [SMSWP_SWITCHES-1:0] ref_state;
	logic [SMSWP_SWITCHES-1:0] snap;
	logic int_own;
	logic [SMSWP_PROG_INPUTS-1:0] polarity;
	smswp_mode_t mode;
	smswp_mode_t next_mode;

	// Edge and event terms
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic int_fall;
	logic wake_fall;
	logic change_now;
	logic snap_change;
	logic int_set;
	logic wake_hit;
	logic wake_by_pin;
	logic wake_by_cs;
	logic wake_by_int;
	logic wake_by_sw;
	logic word_ok;

	// Select, serial, interrupt, wake, supply and thermal pins; CS idles high, SCLK low
	smswp_sync #(
		.WIDTH(7),
		.RESET_VAL(SMSWP_PIN_RESET)
	) u_pin_sync (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.d({CS_N, SCLK, SI, INT_N_I, WAKE_N_I, LOGIC_SUPPLY_OK, THERMAL_FLAG}),
		.q({cs_s, sclk_s, si_s, int_s, wake_s, vdd_s, therm_s})
	);

	// Comparator outputs are asynchronous too
	smswp_sync #(
		.WIDTH(SMSWP_SWITCHES),
		.RESET_VAL('0)
	) u_cmp_sync (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.d({PROG_ABOVE_REF, GND_ABOVE_REF}),
		.q({prog_above_s, gnd_above_s})
	);

	// Polarity applied so every closed contact reads as one
	smswp_decode u_decode (
		.prog_above(prog_above_s),
		.gnd_above(gnd_above_s),
		.polarity(polarity),
		.prog_closed(prog_closed),
		.gnd_closed(gnd_closed)
	);

	assign closed = {prog_closed, gnd_closed};

	// Builds the outgoing status word
	function automatic logic [SMSWP_WORD_BITS-1:0] status_word(
		input logic int_flag,
		input logic therm,
		input logic [SMSWP_PROG_INPUTS-1:0] prog,
		input logic [SMSWP_GND_INPUTS-1:0] gnd
	);
		logic [SMSWP_WORD_BITS-1:0] w;
		w = SMSWP_WORD_RESET;
		w[SMSWP_STAT_INT_POS] = int_flag;
		w[SMSWP_STAT_THERM_POS] = therm;
		w[SMSWP_STAT_PROG_LSB +: SMSWP_PROG_INPUTS] = prog;
		w[SMSWP_STAT_GND_LSB +: SMSWP_GND_INPUTS] = gnd;
		return w;
	endfunction

	// Delayed copies for edge detection
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			cs_d <= 1'b1;
			sclk_d <= 1'b0;
			int_d <= 1'b1;
			wake_d <= 1'b1;
		end else begin
			cs_d <= cs_s;
			sclk_d <= sclk_s;
			int_d <= int_s;
			wake_d <= wake_s;
		end
	end

	// Without the logic supply the serial port is dead
	// A select edge seen without the supply is dropped, so no half frame applies
	assign cs_fall = cs_d & ~cs_s & vdd_s;
	assign cs_rise = ~cs_d & cs_s & vdd_s;
	// Clock edges only count while selected
	assign sclk_rise = ~sclk_d & sclk_s & ~cs_s & ~cs_d;
	assign sclk_fall = sclk_d & ~sclk_s & ~cs_s & ~cs_d;
	assign int_fall = int_d & ~int_s;
	assign wake_fall = wake_d & ~wake_s;

	// Shared shift register: status loaded at select, command shifted in
	// An edge on SCLK while CS moves is undefined; the host avoids it
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			shreg <= SMSWP_WORD_RESET;
		end else if (cs_fall) begin
			// Interrupt bit needs both own request and a low line
			shreg <= status_word(int_own & ~int_s, therm_s, prog_closed,
				gnd_closed);
		end else if (sclk_fall) begin
			shreg <= {shreg[SMSWP_WORD_BITS-2:0], si_s};
		end
	end

	// Count falling edges; saturation keeps long frames invalid
	// Only falls are counted: a frame ends on a fall, before the host deselects
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			fall_cnt <= '0;
		end else if (cs_fall) begin
			fall_cnt <= '0;
		end else if (sclk_fall && fall_cnt != SMSWP_CNT_MAX) begin
			fall_cnt <= fall_cnt + SMSWP_CNT_ONE;
		end
	end

	// Output bit: each rising edge shows the current MSB
	// Off the pin the bit may hold stale data; the driver enable hides it
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			so_bit <= 1'b0;
		end else if (cs_fall) begin
			so_bit <= 1'b0;
		end else if (sclk_rise) begin
			so_bit <= shreg[SMSWP_WORD_BITS-1];
		end
	end

	// Output driver follows select, and turns off when the logic supply drops
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			so_en <= 1'b0;
		end else if (cs_fall) begin
			so_en <= 1'b1;
		end else if (cs_rise || !vdd_s) begin
			so_en <= 1'b0;
		end
	end

	assign SO_O = so_bit;
	assign SO_OE = so_en;

	// A short or long frame would misplace every field
	assign word_ok = (fall_cnt == SMSWP_CNT_FULL);

	// Command applied at deselect
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			CMD_WORD <= SMSWP_WORD_RESET;
			CMD_STROBE <= 1'b0;
		end else begin
			CMD_STROBE <= cs_rise & word_ok;
			if (cs_rise && word_ok) begin
				CMD_WORD <= shreg;
			end
		end
	end

	// Polarity register, battery setting after reset
	// Other opcodes reach the outside only through CMD_WORD
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			polarity <= SMSWP_POL_RESET;
		end else if (cs_rise && word_ok &&
			shreg[SMSWP_CMD_OP_MSB:SMSWP_CMD_OP_LSB] == SMSWP_CMD_OP_SETTINGS) begin
			polarity <= shreg[SMSWP_CMD_POL_LSB +: SMSWP_PROG_INPUTS];
		end
	end

	assign POLARITY = polarity;

	// Change detection against the last acknowledged states
	assign change_now = |((closed ^ ref_state) & IRQ_ENABLE);
	// Change since the snapshot the host is reading now
	assign snap_change = |((closed ^ snap) & IRQ_ENABLE);
	assign int_set = (mode == SMSWP_NORMAL) & change_now & ~cs_rise;

	// Snapshot of switch states taken at select
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			snap <= '0;
		end else if (cs_fall) begin
			snap <= closed;
		end
	end

	// Reference moves to what the host was shown
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ref_state <= '0;
		end else if (cs_rise) begin
			ref_state <= snap;
		end
	end

	// Own interrupt; a change during select survives the release
	// Release and a fresh change in one cycle: the snapshot compare lets the set win
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			int_own <= 1'b0;
		end else if (cs_rise) begin
			int_own <= snap_change & (mode == SMSWP_NORMAL);
		end else if (int_set) begin
			int_own <= 1'b1;
		end
	end

	// Open drain: only ever pulls low
	assign INT_N_O = 1'b0;
	assign INT_N_OE = int_own;

	// Wake sources, each gated by the supply and line levels it depends on
	assign wake_by_pin = wake_fall & (~vdd_s | int_s);
	assign wake_by_cs = vdd_s & cs_fall;
	assign wake_by_int = vdd_s & int_fall & wake_s;
	// A switch change wakes only through the enabled inputs
	assign wake_by_sw = change_now;
	// One merged wake term, so coincident sources give one transition
	assign wake_hit = wake_by_pin | wake_by_cs | wake_by_int | wake_by_sw;

	// Mode transition logic
	always_comb begin
		next_mode = mode;
		unique case (mode)
			SMSWP_NORMAL: begin
				if (SLEEP_REQ) begin
					next_mode = SMSWP_SLEEP;
				end
			end
			SMSWP_SLEEP: begin
				if (wake_hit) begin
					next_mode = SMSWP_NORMAL;
				end
			end
		endcase
	end

	// Mode register, normal after power-on
	// Only the sleep request leaves normal mode; every wake source returns to it
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			mode <= SMSWP_NORMAL;
		end else begin
			mode <= next_mode;
		end
	end

	// Wake pin drives the supply enable low while awake
	assign WAKE_N_O = 1'b0;
	assign WAKE_N_OE = (mode == SMSWP_NORMAL);
	assign SLEEP_MODE = (mode == SMSWP_SLEEP);

endmodule

// ### sim/smswp_host.sv
// Host serial master model for the switch monitor port
`timescale 1ns/10ps
module smswp_host (
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	// One frame of n clocks, 100 ns phases; clock low at both select edges
	task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
		rx = 24'h000000;
		cs_n = 1'b0;
		#200;
		for (int i = 0; i < n; i++) begin
			si = tx[23 - i % 24];
			sclk = 1'b1;
			#100;
			rx = {rx[22:0], so};
			sclk = 1'b0;
			#100;
		end
		cs_n = 1'b1;
		si = ~si; // Released data must not look held
		#200;
	endtask
endmodule

// ### sim/smswp_monitor.sv
// Port checker for the switch monitor serial and wake port
`timescale 1ns/10ps
module smswp_monitor
	import smswp_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic LOGIC_SUPPLY_OK,
	input wire logic SO_O,
	input wire logic SO_OE,
	input wire logic INT_N_O,
	input wire logic INT_N_OE,
	input wire logic WAKE_N_O,
	input wire logic WAKE_N_OE,
	input wire logic SLEEP_REQ,
	input wire logic SLEEP_MODE,
	input wire logic [SMSWP_PROG_INPUTS-1:0] POLARITY,
	input wire logic [SMSWP_WORD_BITS-1:0] CMD_WORD,
	input wire logic CMD_STROBE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// Output pin timing against select and serial clock
	a_so_idle: assert property (CS_N [*5] |-> !SO_OE)
		else $error("so driven while idle");
	a_so_enable: assert property (($fell(CS_N) && LOGIC_SUPPLY_OK) ##1
		(!CS_N && LOGIC_SUPPLY_OK) [*4] |-> SO_OE) else $error("so not enabled");
	a_so_shift: assert property ($changed(SO_O) && $past(SO_OE) |->
		SCLK && $past(SCLK, 2)) else $error("so moved off clock rise");
	a_so_quiet: assert property ($changed(SO_O) |-> SO_OE)
		else $error("so moved while off");
	// Command acceptance is a single marked event
	a_strobe_one: assert property (CMD_STROBE |=> !CMD_STROBE)
		else $error("strobe too long");
	a_word_strobe: assert property ($changed(CMD_WORD) |-> CMD_STROBE && CS_N)
		else $error("word without strobe");
	a_pol_cmd: assert property ($changed(POLARITY) |->
		CMD_WORD[SMSWP_CMD_OP_MSB:SMSWP_CMD_OP_LSB] == SMSWP_CMD_OP_SETTINGS)
		else $error("polarity without settings");
	// Interrupt pull only released at deselect, only raised while awake
	a_int_release: assert property ($fell(INT_N_OE) |-> CS_N)
		else $error("interrupt released while selected");
	a_int_awake: assert property ($rose(INT_N_OE) |-> !$past(SLEEP_MODE))
		else $error("interrupt raised in sleep");
	// Mode and open-drain outputs
	a_wake_mode: assert property ((WAKE_N_OE != SLEEP_MODE) &&
		!WAKE_N_O && !INT_N_O) else $error("wake pin wrong");
	a_sleep_go: assert property (SLEEP_REQ && !SLEEP_MODE |=> SLEEP_MODE)
		else $error("sleep not entered");
	c_strobe: cover property (CMD_STROBE);
	c_int: cover property ($rose(INT_N_OE));
	c_sleep: cover property ($rose(SLEEP_MODE));
	c_wake: cover property ($fell(SLEEP_MODE));
endmodule
bind smswp_top smswp_monitor u_mon (.CORE_CLK, .RST_N, .CS_N, .SCLK, .LOGIC_SUPPLY_OK,
	.SO_O, .SO_OE, .INT_N_O, .INT_N_OE, .WAKE_N_O, .WAKE_N_OE, .SLEEP_REQ, .SLEEP_MODE,
	.POLARITY, .CMD_WORD, .CMD_STROBE);

// ### sim/smswp_top_test.sv
// Self-checking bench for the switch monitor serial and wake port
`timescale 1ns/10ps
module smswp_top_test
	import smswp_pkg::*;
();
	logic clk, rst_n, sup, therm, sleep_req, ext_int, ext_wake;
	logic [7:0] pa, pol;
	logic [13:0] ga;
	logic [21:0] ien;
	logic [23:0] tx, rx, last;
	logic [31:0] r;
	int seed, n_mismatch, n_tests, n_stb;
	int lens [3] = '{0, 23, 25};
	wire so_o, so_oe, int_oe, wake_oe, sleep, stb, cs_n, sclk, si;
	wire [7:0] polr;
	wire [23:0] cmd;
	// Pulled-up shared lines; an undriven output shows the inverse level
	wire int_line = !(int_oe || ext_int);
	wire wake_line = !(wake_oe || ext_wake);
	wire so_line = so_oe ? so_o : !so_o;
	smswp_host host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_line));
	smswp_top dut (.CORE_CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SI(si),
		.SO_O(so_o), .SO_OE(so_oe), .INT_N_I(int_line), .INT_N_O(), .INT_N_OE(int_oe),
		.WAKE_N_I(wake_line), .WAKE_N_O(), .WAKE_N_OE(wake_oe), .LOGIC_SUPPLY_OK(sup),
		.THERMAL_FLAG(therm), .PROG_ABOVE_REF(pa), .GND_ABOVE_REF(ga), .IRQ_ENABLE(ien),
		.SLEEP_REQ(sleep_req), .SLEEP_MODE(sleep), .POLARITY(polr), .CMD_WORD(cmd),
		.CMD_STROBE(stb));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Accepted commands, counted away from the edge that launches the strobe
	always @(negedge clk) begin
		if (stb === 1'b1) n_stb++;
	end
	// Status expected from current pins; closed reads one
	function automatic logic [23:0] exp_stat(input logic irq);
		return {irq, therm, ~(pa ^ pol), ~ga};
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_w(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected word at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected bit at %0t: %b not %b", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Bounded wait on mode or interrupt; running out ends the run
	task automatic wait_sig(input logic w, input logic v);
		for (int i = 0; i < 40; i++) begin
			if ((w ? sleep : int_oe) === v) return;
			step(1);
		end
		n_mismatch++;
		$display("unexpected timeout at %0t", $time);
		wrap_up;
	endtask
	task automatic pulse(input logic w);
		if (w) ext_wake = 1'b1;
		else ext_int = 1'b1;
		step(6);
		ext_wake = 1'b0;
		ext_int = 1'b0;
		step(2);
	endtask
	initial begin
		seed = 22955;
		n_mismatch = 0;
		n_tests = 0;
		n_stb = 0;
		{rst_n, sleep_req, ext_int, ext_wake, therm} = 5'h00;
		sup = 1'b1;
		{pa, ga, ien} = 44'h000;
		pol = 8'hff;
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		step(4);
		chk_b(so_oe, 1'b0);
		chk_b(wake_oe, 1'b1);
		chk_w({16'h0000, polr}, 24'h0000ff);
		$display("reset test done");
		// Random switches and commands, settings opcode on even frames and the last
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			{therm, ga, pa} = r[22:0];
			r = $random(seed);
			tx = (k == 7) ? 24'h0100a5 : {(k % 2 == 0) ? 8'h01 : r[23:16], r[15:0]};
			step(4);
			host.xfer(tx, 24, rx);
			chk_w(rx, exp_stat(1'b0));
			chk_w(cmd, tx);
			chk_w(24'(n_stb), 24'(k + 1));
			chk_b(so_oe, 1'b0);
			chk_b(int_oe, 1'b0);
			if (tx[23:16] == 8'h01) pol = tx[7:0];
			chk_w({16'h0000, polr}, {16'h0000, pol});
		end
		// Frames with a wrong clock count must change nothing
		foreach (lens[i]) begin
			last = cmd;
			host.xfer({8'h01, 8'h00, ~pol}, lens[i], rx);
			chk_w(cmd, last);
			chk_w({16'h0000, polr}, {16'h0000, pol});
			chk_w(24'(n_stb), 24'h000008);
		end
		$display("frame tests done");
		// Enabled change raises the interrupt, a read clears it
		ien = 22'h3fffff;
		host.xfer(24'h000000, 24, rx);
		chk_b(int_oe, 1'b0);
		ga[0] = ~ga[0];
		wait_sig(1'b0, 1'b1);
		host.xfer(24'h000000, 24, rx);
		chk_w(rx, exp_stat(1'b1));
		chk_b(int_oe, 1'b0);
		ext_int = 1'b1;
		host.xfer(24'h000000, 24, rx);
		ext_int = 1'b0;
		chk_b(rx[23], 1'b0);
		ga[1] = ~ga[1];
		wait_sig(1'b0, 1'b1);
		fork
			host.xfer(24'h000000, 24, rx);
			#2000 ga[2] = ~ga[2];
		join
		chk_b(int_oe, 1'b1);
		host.xfer(24'h000000, 24, rx);
		chk_b(int_oe, 1'b0);
		$display("interrupt test done");
		// Wake pin, select and interrupt line wakes; without the logic supply select and line are ignored
		for (int k = 0; k < 4; k++) begin
			sleep_req = 1'b1;
			step(1);
			sleep_req = 1'b0;
			step(3);
			chk_b(wake_oe, 1'b0);
			if (k == 3) begin
				sup = 1'b0;
				step(4);
				host.xfer(24'h000000, 24, rx);
				pulse(1'b0);
				chk_b(sleep, 1'b1);
			end
			if (k == 1) host.xfer(24'h000000, 24, rx);
			else pulse(k != 2);
			wait_sig(1'b1, 1'b0);
			chk_b(wake_oe, 1'b1);
			sup = 1'b1;
			step(4);
		end
		$display("sleep test done");
		wrap_up;
	end
endmodule
